/* File: design/power_monitor_pkg.sv */
// shared constants, types and timing for the power monitor measurement block
package power_monitor_pkg;

	////////////////////////////////////////////////////////////////////////////
	// register pointers and layout
	localparam logic [7:0]  ptr_config     = 8'h00;    // configuration pointer
	localparam logic [7:0]  ptr_sense      = 8'h01;    // shunt result pointer
	localparam logic [7:0]  ptr_rail       = 8'h02;    // bus result pointer
	localparam logic [7:0]  ptr_power      = 8'h03;    // power result pointer
	localparam logic [15:0] config_reset   = 16'h4127; // power-on configuration
	localparam logic [15:0] result_reset   = 16'h0000; // power-on result value
	localparam int          reset_bit      = 15;       // self-clearing reset request
	localparam int          avg_lsb        = 9;        // sample_count_select field
	localparam int          rail_ct_lsb    = 6;        // rail_conversion_time_select
	localparam int          sense_ct_lsb   = 3;        // sense_conversion_time_select
	localparam int          field_w        = 3;        // width of each 3-bit field
	localparam int          mode_sense_bit = 0;        // mode: convert shunt channel
	localparam int          mode_rail_bit  = 1;        // mode: convert bus channel
	localparam int          mode_cont_bit  = 2;        // mode: continuous when set

	////////////////////////////////////////////////////////////////////////////
	// timing
	localparam int clock_mhz = 40; // device clock rate
	// conversion times in ns, per 3-bit selector code
	localparam int conv_time_ns [8] = '{140000, 204000, 332000, 588000,
		1100000, 2116000, 4156000, 8244000};
	localparam int cnt_w = 20; // wide enough for the longest conversion

	typedef logic [7:0][cnt_w-1:0] conv_table_t;

	// conversion times turned into clock cycles, never below one
	function automatic conv_table_t conv_cycles_of();
		conv_table_t t;
		int          c;
		for (int i = 0; i < 8; i++) begin
			c = (conv_time_ns[i] * clock_mhz) / 1000;
			t[i] = cnt_w'((c < 1) ? 1 : c);
		end
		return t;
	endfunction

	localparam conv_table_t conv_cycles_default = conv_cycles_of();

	// averaging counts 1,4,16,64,128,256,512,1024 as powers of two
	localparam logic [3:0] avg_shift [8] = '{4'h0, 4'h2, 4'h4, 4'h6,
		4'h7, 4'h8, 4'h9, 4'hA};

	////////////////////////////////////////////////////////////////////////////
	// types
	typedef enum {conv_idle, conv_sense, conv_rail} conv_state_t;

	// one byte-level serial bus event, already decoded from the wire
	typedef struct packed {
		logic       frame_start; // start of a new bus transaction
		logic       ptr_valid;   // data holds a new pointer
		logic       wr_valid;    // data holds a register byte
		logic       rd_req;      // controller fetches the next byte
		logic [7:0] data;        // byte written by the controller
	} host_req_t;

	typedef struct packed {
		logic       rd_valid; // rd_data holds a fetched byte
		logic [7:0] rd_data;  // byte returned to the controller
	} host_ans_t;

	// raw converter output, sampled at the end of each conversion
	typedef struct packed {
		logic [15:0] sense_resistor_reading; // signed shunt sample
		logic [14:0] rail_reading;           // unsigned bus sample
		logic [15:0] power_value;            // product from the multiplier
	} adc_sample_t;

endpackage

/* File: design/sample_averager.sv */
// accumulate-and-divide averager for one measurement channel
`timescale 1ns/1ps
module sample_averager (
	input  wire logic               clock,
	input  wire logic               rst,
	input  wire logic               clear,
	input  wire logic               add,
	input  wire logic               finish,
	input  wire logic signed [16:0] sample,
	input  wire logic        [3:0]  shift,
	output logic             [15:0] result
);
	import power_monitor_pkg::*;

	localparam int acc_w = 28; // 17-bit sample plus 1024 summands

	logic signed [acc_w-1:0] acc;   // running sum of this sequence
	logic signed [acc_w-1:0] sum;   // sum including the current sample
	logic signed [acc_w-1:0] mean;  // sum divided by the count

	assign sum  = acc + acc_w'(sample);
	assign mean = sum >>> shift;

	////////////////////////////////////////////////////////////////////////////
	// running sum, emptied at each sequence start or final sample
	always_ff @(posedge clock) begin
		if (rst || clear) begin
			acc <= '0;
		end else if (add && finish) begin
			acc <= '0;
		end else if (add) begin
			acc <= sum;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// published value; clear does not touch it so readers keep the old one
	always_ff @(posedge clock) begin
		if (rst) begin
			result <= result_reset;
		end else if (add && finish) begin
			result <= mean[15:0];
		end
	end

endmodule

/* File: design/power_monitor_config_results.sv */
// configuration decode, conversion sequencing and result registers
//
// Contract
// - averaging code selects 1 to 1024 samples
// - bits 8:6 select bus conversion time
// - bits 5:3 select shunt conversion time
// - bits 2:0 select power-down, triggered, continuous
// - reset mode converts both channels continuously
// - shunt result is 16-bit two's complement
// - shunt count weighs 2.5 uV, 7FFF full-scale
// - results show averaged values when averaging
// - bus result replaced at the end of each completed averaged set of conversions
// - bus result bits 14:0, bit 15 zero
// - shunt result read-only at 01h, reset zero
// - bus result read-only at 02h, reset zero
// - power result read-only at 03h, reset zero
// - configuration write aborts, then restarts conversion
// - bit 15 write resets all, self-clears
// - registers move as two bytes, MSB first
`timescale 1ns/1ps
module power_monitor_config_results #(
	parameter power_monitor_pkg::conv_table_t conv_cycles = power_monitor_pkg::conv_cycles_default
) (
	input  wire logic                           clock,
	input  wire logic                           rst,
	input  wire power_monitor_pkg::host_req_t   req,
	input  wire power_monitor_pkg::adc_sample_t adc,
	output power_monitor_pkg::host_ans_t        ans,
	output logic                                results_updated
);
	import power_monitor_pkg::*;

	////////////////////////////////////////////////////////////////////////////
	// state
	logic [15:0]       cfg;          // measurement_configuration, bit 15 stays 0
	logic              sw_clear;     // one-cycle soft reset after a bit-15 write
	logic              local_rst;    // hard or soft reset
	logic [7:0]        ptr;          // register pointer
	logic              wr_phase;     // 1 once the high write byte is held
	logic [7:0]        wr_high;      // held high write byte
	logic              rd_phase;     // 1 once the high read byte went out
	logic [7:0]        rd_low;       // low read byte, captured with the high
	logic              halt;         // configuration write under way
	logic              restart;      // a new sequence is owed
	conv_state_t       state;        // conversion sequencer
	logic [cnt_w-1:0]  cnt;          // cycles into the current conversion
	logic [10:0]       round;        // averaging round index

	////////////////////////////////////////////////////////////////////////////
	// decode
	logic [2:0]        avg_code;     // sample_count_select
	logic [3:0]        shift;        // log2 of the sample count
	logic [10:0]       need;         // samples per result
	logic [cnt_w-1:0]  sense_ct;     // shunt conversion length
	logic [cnt_w-1:0]  rail_ct;      // bus conversion length
	logic              sense_en;     // shunt channel selected
	logic              rail_en;      // bus channel selected
	logic              cont;         // continuous mode
	logic              cfg_first;    // high byte of a configuration write
	logic              commit;       // low byte completes a configuration write
	logic              start_seq;    // sequencer leaves idle
	logic              sense_done;   // shunt conversion ends this cycle
	logic              rail_done;    // bus conversion ends this cycle
	logic              round_end;    // all selected channels converted
	logic              last_round;   // this round completes the average
	logic [15:0]       wr_word;      // assembled write word
	logic [15:0]       rd_word;      // register selected for reading
	logic [15:0]       sense_result; // shunt_voltage_result
	logic [15:0]       rail_result;  // bus_voltage_result
	logic [15:0]       power_result; // power_result

	assign local_rst  = rst || sw_clear;
	assign avg_code   = cfg[avg_lsb +: field_w];
	assign shift      = avg_shift[avg_code];
	assign need       = 11'h001 << shift;
	assign rail_ct    = conv_cycles[cfg[rail_ct_lsb +: field_w]];
	assign sense_ct   = conv_cycles[cfg[sense_ct_lsb +: field_w]];
	assign sense_en   = cfg[mode_sense_bit];
	assign rail_en    = cfg[mode_rail_bit];
	assign cont       = cfg[mode_cont_bit];
	assign wr_word    = {wr_high, req.data};
	assign cfg_first  = req.wr_valid && !wr_phase && ptr == ptr_config;
	assign commit     = req.wr_valid && wr_phase && ptr == ptr_config;
	assign start_seq  = state == conv_idle && !halt && restart && (sense_en || rail_en);
	assign sense_done = state == conv_sense && cnt == sense_ct - 20'h00001;
	assign rail_done  = state == conv_rail && cnt == rail_ct - 20'h00001;
	assign round_end  = (sense_done && !rail_en) || rail_done;
	assign last_round = round == need - 11'h001;

	////////////////////////////////////////////////////////////////////////////
	// configuration register; a bit-15 write leaves cfg to the soft reset
	always_ff @(posedge clock) begin
		if (local_rst) begin
			cfg <= config_reset;
		end else if (commit && !wr_word[reset_bit]) begin
			cfg <= {1'b0, wr_word[14:0]};
		end
	end

	// soft reset pulse, itself cleared only by the next cycle
	always_ff @(posedge clock) begin
		if (rst) begin
			sw_clear <= 1'b0;
		end else begin
			sw_clear <= commit && wr_word[reset_bit] && !sw_clear;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// pointer and byte pairing; a new pointer or frame restarts the pair
	always_ff @(posedge clock) begin
		if (local_rst) begin
			ptr      <= ptr_config;
			wr_phase <= 1'b0;
			wr_high  <= 8'h00;
		end else if (req.frame_start || req.ptr_valid) begin
			if (req.ptr_valid) begin
				ptr <= req.data;
			end
			wr_phase <= 1'b0;
		end else if (req.wr_valid) begin
			wr_phase <= !wr_phase;
			wr_high  <= req.data;
		end
	end

	// read side: high byte first, low byte frozen with it so pairs never tear
	always_ff @(posedge clock) begin
		if (local_rst) begin
			rd_phase <= 1'b0;
			rd_low   <= 8'h00;
			ans      <= '0;
		end else begin
			ans.rd_valid <= req.rd_req;
			if (req.frame_start || req.ptr_valid) begin
				rd_phase <= 1'b0;
			end else if (req.rd_req && !rd_phase) begin
				ans.rd_data <= rd_word[15:8];
				rd_low      <= rd_word[7:0];
				rd_phase    <= 1'b1;
			end else if (req.rd_req) begin
				ans.rd_data <= rd_low;
				rd_phase    <= 1'b0;
			end
		end
	end

	// read mux; result pointers have no write path at all
	always_comb begin
		unique case (ptr)
			ptr_config: rd_word = cfg;
			ptr_sense:  rd_word = sense_result;
			ptr_rail:   rd_word = rail_result;
			ptr_power:  rd_word = power_result;
			default:    rd_word = 16'h0000;
		endcase
	end

	////////////////////////////////////////////////////////////////////////////
	// halt while a configuration word is half written, then owe a restart
	always_ff @(posedge clock) begin
		if (local_rst) begin
			halt    <= 1'b0;
			restart <= 1'b1;
		end else if (cfg_first) begin
			halt <= 1'b1;
		end else if (commit) begin
			halt    <= 1'b0;
			restart <= 1'b1;
		end else if (start_seq) begin
			restart <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// conversion sequencer: shunt then bus per round, rounds up to the count
	always_ff @(posedge clock) begin
		if (local_rst || cfg_first) begin
			state <= conv_idle;
			cnt   <= '0;
			round <= 11'h000;
		end else begin
			unique case (state)
				conv_idle: begin
					cnt   <= '0;
					round <= 11'h000;
					if (start_seq) begin
						state <= sense_en ? conv_sense : conv_rail;
					end
				end
				conv_sense: begin
					cnt <= sense_done ? '0 : cnt + 20'h00001;
					if (sense_done && rail_en) begin
						state <= conv_rail;
					end
				end
				conv_rail: begin
					cnt <= rail_done ? '0 : cnt + 20'h00001;
				end
			endcase
			if (round_end && last_round) begin
				round <= 11'h000;
				// triggered mode parks here until the next configuration write
				state <= !cont ? conv_idle : (sense_en ? conv_sense : conv_rail);
			end else if (round_end) begin
				round <= round + 11'h001;
				state <= sense_en ? conv_sense : conv_rail;
			end
		end
	end

	// pulse once a full averaged set has been published
	always_ff @(posedge clock) begin
		if (local_rst) begin
			results_updated <= 1'b0;
		end else begin
			results_updated <= round_end && last_round;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// averagers: shunt, bus, power; power follows the bus conversion
	logic               ch_add    [3];
	logic signed [16:0] ch_sample [3];
	logic        [15:0] ch_result [3];

	assign ch_add[0]    = sense_done;
	assign ch_add[1]    = rail_done;
	assign ch_add[2]    = rail_done;
	// shunt keeps its sign, 2.5 uV per count with 7FFF at full scale
	assign ch_sample[0] = {adc.sense_resistor_reading[15], adc.sense_resistor_reading};
	assign ch_sample[1] = {2'b00, adc.rail_reading};
	assign ch_sample[2] = {1'b0, adc.power_value};

	genvar ch;
	generate
		for (ch = 0; ch < 3; ch++) begin : g_avg
			sample_averager u_avg (
				.clock  (clock),
				.rst    (local_rst),
				.clear  (start_seq || cfg_first),
				.add    (ch_add[ch]),
				.finish (last_round),
				.sample (ch_sample[ch]),
				.shift  (shift),
				.result (ch_result[ch])
			);
		end
	endgenerate

	assign sense_result = ch_result[0];
	assign rail_result  = {1'b0, ch_result[1][14:0]};
	assign power_result = ch_result[2];

	////////////////////////////////////////////////////////////////////////////
	// checks
	sequence s_reset_write;
		commit && wr_word[reset_bit];
	endsequence

	sequence s_soft_reset_done;
		sw_clear ##1 (cfg == config_reset && sense_result == result_reset);
	endsequence

	property p_cfg_default;
		@(posedge clock) $fell(rst) |-> cfg == config_reset && cont && sense_en && rail_en;
	endproperty
	a_cfg_default: assert property (p_cfg_default) else $error("bad configuration after reset");

	property p_soft_reset;
		@(posedge clock) disable iff (rst) s_reset_write |=> s_soft_reset_done;
	endproperty
	a_soft_reset: assert property (p_soft_reset) else $error("bit 15 write did not reset");

	property p_abort;
		@(posedge clock) disable iff (rst) cfg_first |=> state == conv_idle && halt;
	endproperty
	a_abort: assert property (p_abort) else $error("configuration write did not abort");

	property p_restart;
		@(posedge clock) disable iff (rst)
			commit && !wr_word[reset_bit] && (wr_word[mode_sense_bit] || wr_word[mode_rail_bit])
			|=> ##[0:2] state != conv_idle;
	endproperty
	a_restart: assert property (p_restart) else $error("no restart after configuration write");

	property p_avg_max;
		@(posedge clock) disable iff (rst) avg_code == 3'h7 |-> need == 11'h400;
	endproperty
	a_avg_max: assert property (p_avg_max) else $error("1024-sample decode wrong");

	property p_sense_len;
		@(posedge clock) disable iff (rst) state == conv_sense |-> cnt < sense_ct;
	endproperty
	a_sense_len: assert property (p_sense_len) else $error("shunt conversion overran");

	property p_rail_len;
		@(posedge clock) disable iff (rst) state == conv_rail |-> cnt < rail_ct;
	endproperty
	a_rail_len: assert property (p_rail_len) else $error("bus conversion overran");

	property p_trigger_stop;
		@(posedge clock) disable iff (rst)
			round_end && last_round && !cont && !cfg_first |=> state == conv_idle && !restart;
	endproperty
	a_trigger_stop: assert property (p_trigger_stop) else $error("triggered mode kept running");

	property p_read_pair;
		@(posedge clock) disable iff (local_rst)
			req.rd_req && !rd_phase && !req.frame_start && !req.ptr_valid
			|=> ans.rd_valid && ans.rd_data == $past(rd_word[15:8]) && rd_low == $past(rd_word[7:0]);
	endproperty
	a_read_pair: assert property (p_read_pair) else $error("high byte not sent first");

	// watch the byte actually sent, not the mux that forces the bit
	property p_rail_top;
		@(posedge clock) disable iff (local_rst)
			ptr == ptr_rail && req.rd_req && !rd_phase && !req.frame_start && !req.ptr_valid
			|=> ans.rd_data[7] == 1'b0;
	endproperty
	a_rail_top: assert property (p_rail_top) else $error("bus result bit 15 set");

endmodule

/* File: testbench/bus_host_model.sv */
// serial bus controller model that reads and writes registers byte by byte
`timescale 1ns/1ps
module bus_host_model (
	input  wire logic                         clock,
	output power_monitor_pkg::host_req_t      req,
	input  wire power_monitor_pkg::host_ans_t ans
);
	import power_monitor_pkg::*;

	////////////////////////////////////////////////////////////////////////////
	// idle bus at time zero
	initial begin
		req = '0;
	end

	// one byte event: raise after a falling edge, drop at the next one
	// kind bits: frame, pointer, write, fetch
	task automatic send(input logic [3:0] kind, input logic [7:0] d);
		@(negedge clock);
		{req.frame_start, req.ptr_valid, req.wr_valid, req.rd_req} = kind;
		req.data = d;
		@(negedge clock);
		{req.frame_start, req.ptr_valid, req.wr_valid, req.rd_req} = 4'h0;
		req.data = ~d; // released lane never shows the stale byte
	endtask

	////////////////////////////////////////////////////////////////////////////
	// word write: high byte first, commit on the low byte
	task automatic write_word(input logic [7:0] p, input logic [15:0] w);
		send(4'h8, 8'h00);
		send(4'h4, p);
		send(4'h2, w[15:8]);
		send(4'h2, w[7:0]);
	endtask

	// one fetch, answer expected in the cycle after the request
	task automatic fetch(output logic [7:0] b, output bit ok);
		send(4'h1, 8'h00);
		ok = 0;
		b = 8'h00;
		for (int i = 0; i < 3 && !ok; i++) begin
			if (ans.rd_valid === 1'b1) begin
				b = ans.rd_data;
				ok = 1;
			end else begin
				@(negedge clock);
			end
		end
	endtask

	// word read as two fetches, high byte first
	task automatic read_word(input logic [7:0] p, output logic [15:0] w, output bit ok);
		logic [7:0] hi;
		logic [7:0] lo;
		bit         o1;
		bit         o2;
		send(4'h8, 8'h00);
		send(4'h4, p);
		fetch(hi, o1);
		fetch(lo, o2);
		w = {hi, lo};
		ok = o1 && o2;
	endtask
endmodule

/* File: testbench/power_monitor_config_results_tb.sv */
// self-checking bench for configuration decode and result registers
`timescale 1ns/1ps
module power_monitor_config_results_tb;
	import power_monitor_pkg::*;

	////////////////////////////////////////////////////////////////////////////
	// short conversions: code i lasts 4+i cycles
	localparam conv_table_t cyc = {20'h0000B, 20'h0000A, 20'h00009, 20'h00008,
		20'h00007, 20'h00006, 20'h00005, 20'h00004};

	logic        clock;           // 40 MHz
	logic        rst;             // synchronous, active high
	host_req_t   req;             // byte events from the controller
	host_ans_t   ans;             // fetched bytes
	adc_sample_t adc;             // converter samples
	logic        results_updated; // publish pulse
	int          n_fail;          // mismatches
	int          check_count;     // comparisons
	int          seed;            // random seed
	int          shifts [8] = '{0, 2, 4, 6, 7, 8, 9, 10}; // log2 of sample counts
	logic [15:0] rd;              // last word read
	logic [15:0] sh;              // shunt sample
	logic [14:0] rl;              // bus sample
	logic [15:0] pw;              // power sample
	logic [15:0] sh2;             // second shunt sample
	logic        alt;             // swap shunt samples every cycle
	bit          ok;              // fetch answered
	int          p0;              // reference period
	int          p1;              // compared period
	int          k;               // pulse count

	power_monitor_config_results #(.conv_cycles(cyc)) power_monitor_config_results_i (
		.clock(clock), .rst(rst), .req(req), .adc(adc), .ans(ans), .results_updated(results_updated));
	bus_host_model bus_host_model_i (.clock(clock), .req(req), .ans(ans));

	////////////////////////////////////////////////////////////////////////////
	// clock
	initial begin
		clock = 0;
		forever #12.5 clock = ~clock;
	end

	// shunt input that swaps between two samples while alt is set
	always @(negedge clock) begin
		if (alt) begin
			adc.sense_resistor_reading <= (adc.sense_resistor_reading == sh) ? sh2 : sh;
		end
	end

	// comparison and verdict
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		check_count++;
		if (seen !== exp) begin
			n_fail++;
			$display("Error at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", check_count, n_fail);
		if (n_fail == 0 && check_count > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask

	task automatic give_up();
		n_fail++;
		$display("Error at %0t: wait ran out", $time);
		tally_and_finish();
	endtask

	// reference mean: queue of equal samples, summed, floor-shifted
	function automatic int mean_of(input int v, input int s);
		int q[$];
		int t;
		t = 0;
		repeat (1 << s) q.push_back(v);
		foreach (q[i]) t += q[i];
		return t >>> s;
	endfunction

	////////////////////////////////////////////////////////////////////////////
	// bus and timing helpers
	task automatic read_chk(input logic [7:0] p, input logic [15:0] exp);
		bus_host_model_i.read_word(p, rd, ok);
		if (!ok) give_up();
		check(rd, exp);
	endtask

	// cycles until the next publish pulse, bounded
	task automatic wait_pulse(input int bound, output int n);
		n = 0;
		while (results_updated !== 1'b1) begin
			if (n >= bound) give_up();
			@(negedge clock);
			n++;
		end
		@(negedge clock);
	endtask

	task automatic count_pulses(input int cycles, output int n);
		n = 0;
		repeat (cycles) begin
			@(negedge clock);
			if (results_updated === 1'b1) n++;
		end
	endtask

	// pulse spacing for one configuration word
	task automatic period(input logic [15:0] w, output int p);
		bus_host_model_i.write_word(ptr_config, w);
		wait_pulse(20000, k);
		wait_pulse(20000, p);
	endtask

	////////////////////////////////////////////////////////////////////////////
	// main sequence
	initial begin
		rst = 1;
		adc = '0;
		alt = 0;
		n_fail = 0;
		check_count = 0;
		seed = 31;
		repeat (12) @(posedge clock);
		@(negedge clock);
		rst = 0;
		read_chk(ptr_config, config_reset);
		read_chk(ptr_sense, 16'h0000);
		read_chk(ptr_rail, 16'h0000);
		read_chk(ptr_power, 16'h0000);
		bus_host_model_i.write_word(ptr_power, 16'hA5A5);
		read_chk(ptr_power, 16'h0000);
		read_chk(8'h07, 16'h0000);
		bus_host_model_i.write_word(ptr_config, 16'h7127);
		read_chk(ptr_config, 16'h7127);
		$display("test reset_and_access done");

		// every averaging code with constant samples; every time code
		for (int c = 0; c < 8; c++) begin
			sh = (c == 0) ? 16'h8300 : (c == 1) ? 16'h7FFF : 16'($random(seed));
			rl = 15'($random(seed));
			pw = 16'($random(seed));
			@(negedge clock);
			adc = {sh, rl, pw};
			bus_host_model_i.write_word(ptr_config, {4'h0, 3'(c), 3'(c), 3'(7 - c), 3'b111});
			wait_pulse(40000, k);
			// each round is 15 cycles, plus one idle cycle before the sequencer starts
			check(16'(k), 16'(1 + (15 << shifts[c])));
			read_chk(ptr_sense, 16'(mean_of($signed(sh), shifts[c])));
			read_chk(ptr_rail, {1'b0, 15'(mean_of(int'(rl), shifts[c]))});
			read_chk(ptr_power, 16'(mean_of(int'(pw), shifts[c])));
		end
		// odd 5-cycle rounds see the swapping samples in turn: mean of two values
		sh  = 16'($random(seed));
		sh2 = 16'($random(seed));
		alt = 1;
		bus_host_model_i.write_word(ptr_config, 16'h0209);
		wait_pulse(200, k);
		alt = 0;
		check(16'(k), 16'h0015);
		read_chk(ptr_sense, 16'((2 * int'($signed(sh)) + 2 * int'($signed(sh2))) >>> 2));
		$display("test averaging done");

		// conversion time codes change pulse spacing by the cycle difference
		period(16'h0007, p0);
		period(16'h01FF, p1);
		check(16'(p1 - p0), 16'h000E);
		period(16'h01C5, p0);
		period(16'h003D, p1);
		check(16'(p1 - p0), 16'h0007);
		period(16'h0006, p0);
		period(16'h01C6, p1);
		check(16'(p1 - p0), 16'h0007);
		$display("test conversion_time done");

		// power-down never publishes; triggered publishes once
		for (int m = 0; m < 8; m++) begin
			if (m < 5 && m != 0 && m != 4) begin
				bus_host_model_i.write_word(ptr_config, {13'h0000, 3'(m)});
				count_pulses(300, k);
				check(16'(k), 16'h0001);
			end else if (m == 0 || m == 4) begin
				bus_host_model_i.write_word(ptr_config, {13'h0000, 3'(m)});
				count_pulses(300, k);
				check(16'(k), 16'h0000);
			end
		end
		$display("test modes done");

		// long triggered run cut short by a new short one
		bus_host_model_i.write_word(ptr_config, 16'h0E03);
		count_pulses(50, k);
		check(16'(k), 16'h0000);
		bus_host_model_i.write_word(ptr_config, 16'h0003);
		count_pulses(12000, k);
		check(16'(k), 16'h0001);
		$display("test abort done");

		// software reset restores defaults and clears itself
		bus_host_model_i.write_word(ptr_config, 16'h0007);
		wait_pulse(2000, k);
		bus_host_model_i.write_word(ptr_config, 16'h8000);
		read_chk(ptr_power, 16'h0000);
		read_chk(ptr_config, config_reset);
		$display("test soft_reset done");
		tally_and_finish();
	end
endmodule
